/* hdl/cfm_msg_store.sv */
`timescale 1ns/1ps
module cfm_msg_store (
	input wire logic clk,
	input wire logic reset_n,
	input wire cfm_pkg::cfm_filt_mode_t filter_mode,
	input wire cfm_pkg::cfm_accept_t acceptance_pattern,
	input wire cfm_pkg::cfm_accept_t acceptance_mask,
	input wire logic loopback_en,
	input wire logic rx_irq_en,
	input wire logic tx_irq_en,
	input wire logic ovr_irq_en,
	input wire logic rx_done,
	input wire logic rx_own,
	input wire cfm_pkg::cfm_frame_t rx_frame,
	input wire logic rx_clear,
	input wire logic ovr_clear,
	input wire logic [3:0] fg_rd_addr,
	output logic [7:0] fg_rd_data_ff,
	output logic rx_full_flag_ff,
	output logic [1:0] filter_hit_index_ff,
	output logic rx_overrun_ff,
	output logic rx_ack_en_ff,
	output logic rx_irq_ff,
	output logic ovr_irq_ff,
	input wire logic tx_wr_en,
	input wire logic [1:0] tx_wr_sel,
	input wire logic [3:0] tx_wr_byte,
	input wire logic [7:0] tx_wr_data,
	input wire logic priority_wr_en,
	input wire logic [7:0] priority_wr_data,
	input wire logic [2:0] tx_sched,
	input wire logic [2:0] abort_request,
	input wire logic tx_arb,
	input wire logic tx_done,
	input wire logic tx_fail,
	output logic [2:0] tx_empty_flag_ff,
	output logic [2:0] abort_acknowledge_ff,
	output logic tx_req_ff,
	output logic [1:0] tx_sel_ff,
	output cfm_pkg::cfm_frame_t tx_frame_ff,
	output logic tx_irq_ff
);

	////////////////////////////////////////////////////////////////////////
	// Acceptance filter
	////////////////////////////////////////////////////////////////////////

	logic [7:0] slot_id [4];
	logic [3:0] slot_match;
	logic filt_hit;
	logic [1:0] filt_idx;
	// Route identifier bytes into the four slices according to the mode
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			unique case (filter_mode)
				cfm_pkg::CFM_FILT_SINGLE: slot_id[k] = rx_frame.id[k];
				cfm_pkg::CFM_FILT_DOUBLE: slot_id[k] = rx_frame.id[k % 2];
				cfm_pkg::CFM_FILT_QUAD: slot_id[k] = rx_frame.id[0];
				cfm_pkg::CFM_FILT_CLOSED: slot_id[k] = rx_frame.id[0];
			endcase
		end
	end
	for (genvar k = 0; k < 4; k++) begin : g_slice
		cfm_byte_match u_match (
			.pattern(acceptance_pattern[k]),
			.mask(acceptance_mask[k]),
			.id_byte(slot_id[k]),
			.match(slot_match[k])
		);
	end

	// Combine slices into filters; the lowest matching filter is reported
	always_comb begin
		filt_hit = 1'b0;
		filt_idx = cfm_pkg::CFM_HIT_RST;
		unique case (filter_mode)
			cfm_pkg::CFM_FILT_SINGLE: filt_hit = &slot_match;
			cfm_pkg::CFM_FILT_DOUBLE: begin
				filt_hit = (&slot_match[1:0]) | (&slot_match[3:2]);
				filt_idx = (&slot_match[1:0]) ? 2'h0 : 2'h1;
			end
			cfm_pkg::CFM_FILT_QUAD: begin
				filt_hit = |slot_match;
				if (slot_match[0]) filt_idx = 2'h0;
				else if (slot_match[1]) filt_idx = 2'h1;
				else if (slot_match[2]) filt_idx = 2'h2;
				else filt_idx = 2'h3;
			end
			cfm_pkg::CFM_FILT_CLOSED: filt_hit = 1'b0; // Accepts nothing
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO
	////////////////////////////////////////////////////////////////////////

	cfm_pkg::cfm_frame_t bg_ff;
	cfm_pkg::cfm_frame_t fg_ff;
	logic [1:0] bg_hit_ff;
	logic bg_valid_ff, full_eff, drain, ovr, take, own, accept, direct;
	// A clear in this cycle already frees the foreground for a copy
	assign full_eff = rx_full_flag_ff & ~rx_clear;
	assign drain = bg_valid_ff & ~full_eff;
	assign ovr = rx_done & full_eff & bg_valid_ff;
	assign take = rx_done & ~ovr;
	assign own = rx_own & ~loopback_en;
	assign accept = take & filt_hit & ~own;
	assign direct = accept & ~full_eff & ~bg_valid_ff;

	// Background buffer takes every frame unless overrun
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bg_ff <= '0;
			bg_valid_ff <= 1'b0;
			bg_hit_ff <= cfm_pkg::CFM_HIT_RST;
		end else begin
			if (take) begin
				bg_ff <= rx_frame;
				bg_hit_ff <= filt_idx;
			end
			// Only an accepted frame still waiting for the host stays valid
			if (drain) bg_valid_ff <= accept;
			else if (take) bg_valid_ff <= accept & ~direct;
		end
	end

	// Foreground buffer, flag and hit index; the set wins over a clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fg_ff <= '0;
			rx_full_flag_ff <= 1'b0;
			filter_hit_index_ff <= cfm_pkg::CFM_HIT_RST;
		end else if (drain) begin
			fg_ff <= bg_ff;
			rx_full_flag_ff <= 1'b1;
			filter_hit_index_ff <= bg_hit_ff;
		end else if (direct) begin
			fg_ff <= rx_frame;
			rx_full_flag_ff <= 1'b1;
			filter_hit_index_ff <= filt_idx;
		end else if (rx_clear) begin
			rx_full_flag_ff <= 1'b0;
		end
	end

	// Overrun status is sticky until the host clears it
	always_ff @(posedge clk) begin
		if (!reset_n) rx_overrun_ff <= 1'b0;
		else if (ovr) rx_overrun_ff <= 1'b1;
		else if (ovr_clear) rx_overrun_ff <= 1'b0;
	end

	// Receive events, gated by their enables; acknowledge enable follows ownership, ungated
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_irq_ff <= 1'b0;
			ovr_irq_ff <= 1'b0;
			rx_ack_en_ff <= 1'b1;
		end else begin
			rx_irq_ff <= (drain | direct) & rx_irq_en;
			ovr_irq_ff <= ovr & ovr_irq_en;
			rx_ack_en_ff <= ~own;
		end
	end

	// Host read window onto the foreground; bytes past the buffer read 0
	always_ff @(posedge clk) begin
		if (!reset_n) fg_rd_data_ff <= 8'h00;
		else if (fg_rd_addr <= cfm_pkg::CFM_LAST_BYTE)
			fg_rd_data_ff <= fg_ff[8 * (12 - 32'(fg_rd_addr)) +: 8];
		else fg_rd_data_ff <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit buffers
	////////////////////////////////////////////////////////////////////////

	cfm_pkg::cfm_frame_t tx_buf [cfm_pkg::CFM_NUM_TX];
	logic [7:0] local_priority [cfm_pkg::CFM_NUM_TX];
	logic [2:0] abort_pend_ff, cand, abt_go, sent;
	logic [1:0] pick;
	logic on_bus_ff, found, priority_ok;
	// Scheduled buffers without a pending abort compete at arbitration
	always_comb begin
		cand = ~tx_empty_flag_ff & ~abort_pend_ff;
		pick = 2'h0;
		found = 1'b0;
		for (int i = 0; i < cfm_pkg::CFM_NUM_TX; i++) begin
			if (cand[i] && (!found || local_priority[i] < local_priority[pick])) begin
				pick = 2'(i);
				found = 1'b1;
			end
		end
	end

	// An abort is granted only when the buffer is not on the bus
	always_comb begin
		for (int i = 0; i < cfm_pkg::CFM_NUM_TX; i++) begin
			sent[i] = tx_done & on_bus_ff & (tx_sel_ff == 2'(i));
			abt_go[i] = abort_pend_ff[i] & ~tx_empty_flag_ff[i] &
				~(on_bus_ff & (tx_sel_ff == 2'(i)));
		end
	end

	// Host writes are ignored while a buffer is scheduled
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < cfm_pkg::CFM_NUM_TX; i++) begin
				tx_buf[i] <= '0;
				local_priority[i] <= cfm_pkg::CFM_PRIORITY_RST;
			end
		end else if (tx_wr_sel < 2'h3 && tx_empty_flag_ff[tx_wr_sel]) begin
			if (tx_wr_en && tx_wr_byte <= cfm_pkg::CFM_LAST_BYTE)
				tx_buf[tx_wr_sel][8 * (12 - 32'(tx_wr_byte)) +: 8] <= tx_wr_data;
			if (priority_wr_en)
				local_priority[tx_wr_sel] <= priority_wr_data;
		end
	end

	// Empty, abort acknowledge and abort request per buffer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_empty_flag_ff <= cfm_pkg::CFM_TX_EMPTY_RST;
			abort_acknowledge_ff <= cfm_pkg::CFM_ABORT_ACK_RST;
			abort_pend_ff <= 3'h0;
		end else begin
			for (int i = 0; i < cfm_pkg::CFM_NUM_TX; i++) begin
				if (sent[i]) begin
					tx_empty_flag_ff[i] <= 1'b1;
					abort_acknowledge_ff[i] <= 1'b0;
					abort_pend_ff[i] <= 1'b0;
				end else if (abt_go[i]) begin
					tx_empty_flag_ff[i] <= 1'b1;
					abort_acknowledge_ff[i] <= 1'b1;
					abort_pend_ff[i] <= 1'b0;
				end else if (tx_sched[i] && tx_empty_flag_ff[i]) begin
					tx_empty_flag_ff[i] <= 1'b0;
					abort_acknowledge_ff[i] <= 1'b0;
				end else if (abort_request[i] && !tx_empty_flag_ff[i]) begin
					abort_pend_ff[i] <= 1'b1;
				end
			end
		end
	end

	// Offer the winner at each arbitration; a failure forces a fresh pick
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			on_bus_ff <= 1'b0;
			tx_req_ff <= 1'b0;
			tx_sel_ff <= 2'h0;
			tx_frame_ff <= '0;
		end else if (on_bus_ff) begin
			if (tx_done || tx_fail) begin
				on_bus_ff <= 1'b0;
				tx_req_ff <= 1'b0;
			end
		end else if (tx_arb) begin
			on_bus_ff <= found;
			tx_req_ff <= found;
			tx_sel_ff <= pick;
			tx_frame_ff <= tx_buf[pick];
		end
	end

	// Transmit event on any release, sent or aborted
	always_ff @(posedge clk) begin
		if (!reset_n) tx_irq_ff <= 1'b0;
		else tx_irq_ff <= ((|sent) | (|abt_go)) & tx_irq_en;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////

	// Winner has no larger priority than any other candidate
	always_comb begin
		priority_ok = 1'b1;
		for (int i = 0; i < cfm_pkg::CFM_NUM_TX; i++)
			if (cand[i] && local_priority[i] < local_priority[pick])
				priority_ok = 1'b0;
	end

	AST_RX_COPY: assert property (@(posedge clk) disable iff (!reset_n)
		drain |=> rx_full_flag_ff && fg_ff == $past(bg_ff)
			&& rx_irq_ff == $past(rx_irq_en))
		else $error("pending background frame not copied");
	AST_OVR_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
		ovr |=> bg_ff == $past(bg_ff) && rx_overrun_ff && bg_valid_ff)
		else $error("overrun frame not discarded");
	AST_OWN_STAYS: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_done && own && !drain) |=> $stable(fg_ff) && !rx_irq_ff)
		else $error("own frame reached foreground");
	AST_NO_HIT: assert property (@(posedge clk) disable iff (!reset_n)
		(take && !filt_hit && !drain) |=> $stable(fg_ff) && !bg_valid_ff)
		else $error("rejected frame was accepted");
	AST_SENT_FREE: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_done && on_bus_ff) |=> tx_empty_flag_ff[$past(tx_sel_ff)]
			&& !abort_acknowledge_ff[$past(tx_sel_ff)] && !tx_req_ff)
		else $error("sent buffer not released as sent");
	AST_ABORT_ACK: assert property (@(posedge clk) disable iff (!reset_n)
		(abt_go != 3'h0) |=> (tx_empty_flag_ff & abort_acknowledge_ff
			& $past(abt_go)) == $past(abt_go))
		else $error("abort not acknowledged");
	AST_LOCAL_PRIORITY_PICK: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_arb && !on_bus_ff && found) |-> priority_ok
			##1 (tx_req_ff && tx_sel_ff == $past(pick)))
		else $error("winner is not lowest priority value");
	AST_HIT_SINGLE: assert property (@(posedge clk) disable iff (!reset_n)
		(direct && filter_mode != cfm_pkg::CFM_FILT_QUAD)
			|=> filter_hit_index_ff <= 2'h1)
		else $error("hit index out of range for mode");

endmodule // cfm_msg_store

/* include/cfm_pkg.sv */
package cfm_pkg;

	// Buffer geometry
	localparam int CFM_BUF_BYTES = 13;
	localparam int CFM_NUM_TX = 3;
	localparam int CFM_ID_BYTES = 4;
	localparam logic [3:0] CFM_LAST_BYTE = 4'hC;

	// Reset values
	localparam logic [2:0] CFM_TX_EMPTY_RST = 3'h7;
	localparam logic [2:0] CFM_ABORT_ACK_RST = 3'h0;
	localparam logic [7:0] CFM_PRIORITY_RST = 8'h00;
	localparam logic [1:0] CFM_HIT_RST = 2'h0;

	// Acceptance filter modes
	typedef enum logic [1:0] {
		CFM_FILT_SINGLE,
		CFM_FILT_DOUBLE,
		CFM_FILT_QUAD,
		CFM_FILT_CLOSED
	} cfm_filt_mode_t;

	// One message buffer, byte 0 first: identifier, payload, length code
	typedef struct packed {
		logic [0:3][7:0] id;
		logic [0:7][7:0] data;
		logic [7:0] dlc;
	} cfm_frame_t;

	// Acceptance pattern or mask, byte 0 faces identifier byte 0
	typedef logic [0:3][7:0] cfm_accept_t;

endpackage

/* hdl/cfm_byte_match.sv */
`timescale 1ns/1ps
// One maskable 8-bit comparison slice of the acceptance filter
module cfm_byte_match (
	input wire logic [7:0] pattern,
	input wire logic [7:0] mask,
	input wire logic [7:0] id_byte,
	output logic match
);

	// A mask bit of one turns that identifier bit into a don't-care
	assign match = &(~(pattern ^ id_byte) | mask);

endmodule // cfm_byte_match

/* testbench/cfm_engine_model.sv */
`timescale 1ns/1ps
// Protocol engine stand-in: hands over frames and serves arbitration
module cfm_engine_model (
	input wire logic clk,
	input wire logic tx_req_ff,
	output logic rx_done,
	output logic rx_own,
	output cfm_pkg::cfm_frame_t rx_frame,
	output logic tx_arb,
	output logic tx_done,
	output logic tx_fail
);
	initial begin
		rx_done = 1'b0;
		rx_own = 1'b0;
		rx_frame = '0;
		tx_arb = 1'b0;
		tx_done = 1'b0;
		tx_fail = 1'b0;
	end

	// Frame is valid only in its end cycle; inverted after so stale
	// content differs from the frame in every bit, though an all-ones mask still lets it match
	task automatic send(input cfm_pkg::cfm_frame_t f, input logic own);
		@(negedge clk);
		rx_frame = f;
		rx_own = own;
		rx_done = 1'b1;
		@(negedge clk);
		rx_done = 1'b0;
		rx_own = 1'b0;
		rx_frame = ~f;
	endtask

	// Arbitration attempt, offer is visible when this returns
	task automatic arb();
		@(negedge clk);
		tx_arb = 1'b1;
		@(negedge clk);
		tx_arb = 1'b0;
	endtask

	// Exactly one outcome per offer, and only while a frame is offered
	task automatic finish(input logic ok);
		@(negedge clk);
		tx_done = ok & tx_req_ff;
		tx_fail = ~ok & tx_req_ff;
		@(negedge clk);
		tx_done = 1'b0;
		tx_fail = 1'b0;
	endtask
endmodule // cfm_engine_model

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	cfm_pkg::cfm_filt_mode_t filter_mode = cfm_pkg::CFM_FILT_SINGLE;
	cfm_pkg::cfm_accept_t pat = '0;
	cfm_pkg::cfm_accept_t msk = '0;
	logic loopback_en = 1'b0;
	logic rx_irq_en = 1'b1;
	logic tx_irq_en = 1'b1;
	logic ovr_irq_en = 1'b1;
	logic rx_clear = 1'b0;
	logic ovr_clear = 1'b0;
	logic [3:0] fg_rd_addr = 4'h0;
	logic tx_wr_en = 1'b0;
	logic [1:0] tx_wr_sel = 2'h0;
	logic [3:0] tx_wr_byte = 4'h0;
	logic [7:0] tx_wr_data = 8'h00;
	logic priority_wr_en = 1'b0;
	logic [7:0] priority_wr_data = 8'h00;
	logic [2:0] tx_sched = 3'h0;
	logic [2:0] abort_request = 3'h0;
	logic rx_done, rx_own, tx_arb, tx_done, tx_fail;
	cfm_pkg::cfm_frame_t rx_frame, tx_frame;
	logic [7:0] rd_data;
	logic full, ovr, ack_en, rx_irq, ovr_irq, tx_req, tx_irq;
	logic [1:0] hit, tx_sel;
	logic [2:0] empty, ack;
	int err_total = 0;
	int comparisons = 0;

	always #50 clk = ~clk;

	cfm_engine_model eng (.clk(clk), .tx_req_ff(tx_req), .rx_done(rx_done),
		.rx_own(rx_own), .rx_frame(rx_frame), .tx_arb(tx_arb),
		.tx_done(tx_done), .tx_fail(tx_fail));

	cfm_msg_store dut (.clk(clk), .reset_n(reset_n), .filter_mode(filter_mode),
		.acceptance_pattern(pat), .acceptance_mask(msk),
		.loopback_en(loopback_en), .rx_irq_en(rx_irq_en),
		.tx_irq_en(tx_irq_en), .ovr_irq_en(ovr_irq_en),
		.rx_done(rx_done), .rx_own(rx_own),
		.rx_frame(rx_frame), .rx_clear(rx_clear), .ovr_clear(ovr_clear),
		.fg_rd_addr(fg_rd_addr), .fg_rd_data_ff(rd_data),
		.rx_full_flag_ff(full), .filter_hit_index_ff(hit),
		.rx_overrun_ff(ovr), .rx_ack_en_ff(ack_en), .rx_irq_ff(rx_irq),
		.ovr_irq_ff(ovr_irq), .tx_wr_en(tx_wr_en), .tx_wr_sel(tx_wr_sel),
		.tx_wr_byte(tx_wr_byte), .tx_wr_data(tx_wr_data),
		.priority_wr_en(priority_wr_en),
		.priority_wr_data(priority_wr_data),
		.tx_sched(tx_sched), .abort_request(abort_request), .tx_arb(tx_arb),
		.tx_done(tx_done), .tx_fail(tx_fail), .tx_empty_flag_ff(empty),
		.abort_acknowledge_ff(ack), .tx_req_ff(tx_req), .tx_sel_ff(tx_sel),
		.tx_frame_ff(tx_frame), .tx_irq_ff(tx_irq));

	////////////////////////////////////////////////////////////////////////
	// Verdict and helpers
	task automatic results();
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	// Payload bytes A0..A7 and length code 08 tell the fields apart
	function automatic cfm_pkg::cfm_frame_t mk(input logic [31:0] id);
		cfm_pkg::cfm_frame_t f;
		f.id = id;
		for (int k = 0; k < 8; k++) begin
			f.data[k] = 8'hA0 + 8'(k);
		end
		f.dlc = 8'h08;
		return f;
	endfunction

	task automatic tick();
		@(negedge clk);
	endtask

	// Host releases the foreground after reading it
	task automatic clr();
		rx_clear = 1'b1;
		tick();
		rx_clear = 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		fg_rd_addr = a;
		tick();
		chk("fg byte", {24'h0, e}, {24'h0, rd_data});
	endtask

	// Host fills an empty buffer byte by byte, then its priority
	task automatic wr_buf(input logic [1:0] s, input logic [7:0] p);
		tx_wr_sel = s;
		for (int k = 0; k < cfm_pkg::CFM_BUF_BYTES; k++) begin
			tx_wr_en = 1'b1;
			tx_wr_byte = 4'(k);
			tx_wr_data = {2'h1, s, 4'(k)};
			tick();
		end
		tx_wr_en = 1'b0;
		priority_wr_en = 1'b1;
		priority_wr_data = p;
		tick();
		priority_wr_en = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Receive scenarios
	task automatic t_rx_accept();
		pat = 32'h12345678;
		eng.send(mk(32'h12345678), 1'b0);
		chk("full", 1, full);
		chk("hit", 0, hit);
		chk("rx irq", 1, rx_irq);
		rd(4'h0, 8'h12);
		rd(4'h3, 8'h78);
		rd(4'h4, 8'hA0);
		rd(4'hB, 8'hA7);
		rd(4'hC, 8'h08);
		rd(4'hD, 8'h00);
		clr();
		chk("full cleared", 0, full);
		eng.send(mk(32'h12345679), 1'b0);
		chk("miss", 0, full);
		msk = 32'h00000001;
		eng.send(mk(32'h12345679), 1'b0);
		chk("masked hit", 1, full);
		clr();
	endtask

	// Foreground full plus pending background: third frame is dropped
	task automatic t_overrun();
		msk = 32'h000000FF;
		eng.send(mk(32'h12345601), 1'b0);
		eng.send(mk(32'h12345602), 1'b0);
		chk("no ovr yet", 0, ovr);
		eng.send(mk(32'h99999903), 1'b0);
		chk("ovr", 1, ovr);
		chk("ovr irq", 1, ovr_irq);
		rd(4'h3, 8'h01);
		clr();
		chk("refill", 1, full);
		chk("refill irq", 1, rx_irq);
		rd(4'h3, 8'h02);
		ovr_clear = 1'b1;
		tick();
		ovr_clear = 1'b0;
		chk("ovr clr", 0, ovr);
		clr();
	endtask

	task automatic t_own();
		eng.send(mk(32'h12345611), 1'b1);
		chk("own no copy", 0, full);
		chk("own no ack", 0, ack_en);
		loopback_en = 1'b1;
		eng.send(mk(32'h12345612), 1'b1);
		chk("loop copy", 1, full);
		loopback_en = 1'b0;
		clr();
	endtask

	// Quad, double and closed filter modes, with overlapping quad filters
	task automatic t_modes();
		msk = '0;
		filter_mode = cfm_pkg::CFM_FILT_QUAD;
		pat = 32'h11223333;
		eng.send(mk(32'h33000000), 1'b0);
		chk("quad hit", 2, hit);
		clr();
		filter_mode = cfm_pkg::CFM_FILT_DOUBLE;
		pat = 32'h12345678;
		eng.send(mk(32'h5678FFFF), 1'b0);
		chk("dbl hit", 1, hit);
		clr();
		filter_mode = cfm_pkg::CFM_FILT_CLOSED;
		eng.send(mk(32'h5678FFFF), 1'b0);
		chk("closed", 0, full);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Transmit: priority, tie, abort on and off the bus, reselection
	task automatic t_tx();
		wr_buf(2'h0, 8'h05);
		wr_buf(2'h1, 8'h03);
		wr_buf(2'h2, 8'h03);
		tx_sched = 3'h7;
		tick();
		tx_sched = 3'h0;
		chk("sched", 0, empty);
		eng.arb();
		chk("req", 1, tx_req);
		chk("sel tie", 1, tx_sel);
		chk("tx id", 32'h50515253, tx_frame.id);
		abort_request = 3'h2;
		tick();
		abort_request = 3'h0;
		eng.finish(1'b0);
		tick();
		chk("abort empty", 3'h2, empty);
		chk("abort ack", 3'h2, ack);
		eng.arb();
		chk("resel", 2, tx_sel);
		eng.finish(1'b1);
		chk("sent empty", 3'h6, empty);
		chk("sent ack", 0, ack[2]);
		chk("tx irq", 1, tx_irq);
		abort_request = 3'h1;
		tick();
		abort_request = 3'h0;
		tick();
		chk("abort0", 3'h7, empty);
		chk("ack0", 1, ack[0]);
	endtask

	// Enables low: flags still move but no event pulses; sending goes on
	// while the receive side sits in overrun
	task automatic t_masked();
		rx_irq_en = 1'b0;
		tx_irq_en = 1'b0;
		ovr_irq_en = 1'b0;
		filter_mode = cfm_pkg::CFM_FILT_SINGLE;
		msk = '1;
		eng.send(mk(32'h0000000D), 1'b0);
		chk("masked full", 1, full);
		chk("rx irq masked", 0, rx_irq);
		eng.send(mk(32'h0000000E), 1'b0);
		eng.send(mk(32'h0000000F), 1'b0);
		chk("ovr masked", 1, ovr);
		chk("ovr irq masked", 0, ovr_irq);
		tx_sched = 3'h1;
		tick();
		tx_sched = 3'h0;
		eng.arb();
		chk("ovr sel", 0, tx_sel);
		eng.finish(1'b1);
		chk("ovr sent", 3'h7, empty);
		chk("ack sent", 0, ack[0]);
		chk("tx irq masked", 0, tx_irq);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (20) tick();
		reset_n = 1'b1;
		tick();
		chk("rst empty", 3'h7, empty);
		chk("rst ack", 0, ack);
		chk("rst ack en", 1, ack_en);
		t_rx_accept();
		t_overrun();
		t_own();
		t_modes();
		t_tx();
		t_masked();
		results();
	end

	initial begin
		#2000000;
		err_total++;
		results();
	end
endmodule // tb
